/* File: tb/read_latency_wrap_config_monitor.sv */
// Port checker for the latency and wrap configuration register
`timescale 1ns/1ps
module cfg_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic [7:0] read_wrap_config_nonvolatile,
  input wire logic soft_reset,
  input wire logic quad_peripheral_mode,
  input wire logic [7:0] read_wrap_config_volatile,
  input wire logic [5:0] dummy_cycles,
  input wire logic [2:0] mode_cycles,
  input wire logic wrap_active,
  input wire logic [6:0] wrap_bytes,
  input wire logic cmd_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] code;
  logic [5:0] lat;
  logic qrd;
  // Expected variable latency, code zero maps to eight
  assign code = read_wrap_config_volatile[3:0];
  assign lat = (code == 4'h0) ? 6'h08 : {2'h0, code};
  assign qrd = cmd_valid && mode_cycles != 3'h0;
  cfg_bit7_a: assert property (read_wrap_config_volatile[7] == 1'b0)
    else $error("bit 7 set");
  nv_load_a: assert property ($fell(sys_rst) |=> read_wrap_config_volatile ==
    ($past(read_wrap_config_nonvolatile) & 8'h7f)) else $error("reset load");
  soft_load_a: assert property (soft_reset |=> read_wrap_config_volatile ==
    ($past(read_wrap_config_nonvolatile) & 8'h7f)) else $error("soft load");
  pulse_one_a: assert property (cmd_valid |=> !cmd_valid) else $error("long pulse");
  lat_hold_a: assert property (!cmd_valid |-> $stable(dummy_cycles) && $stable(wrap_active))
    else $error("latency moved");
  wrap_size_a: assert property (cmd_valid |-> wrap_bytes ==
    (7'h08 << read_wrap_config_volatile[6:5])) else $error("wrap size");
  quad_lat_a: assert property (qrd |-> dummy_cycles == lat) else $error("quad latency");
  quad_wrap_a: assert property (qrd |-> wrap_active == !read_wrap_config_volatile[4])
    else $error("wrap flag");
  plain_wrap_a: assert property (cmd_valid && mode_cycles == 3'h0 && !quad_peripheral_mode
    |-> !wrap_active) else $error("plain wrap");
  idle_quiet_a: assert property (cs_n [*8] |-> !so_oe) else $error("so driven idle");
  cover property (qrd && wrap_active);
  cover property (soft_reset);
  cover property (so_oe);
endmodule
bind read_latency_wrap_config cfg_monitor i_mon (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .cs_n(cs_n),
  .so_oe(so_oe),
  .read_wrap_config_nonvolatile(read_wrap_config_nonvolatile),
  .soft_reset(soft_reset),
  .quad_peripheral_mode(quad_peripheral_mode),
  .read_wrap_config_volatile(read_wrap_config_volatile),
  .dummy_cycles(dummy_cycles),
  .mode_cycles(mode_cycles),
  .wrap_active(wrap_active),
  .wrap_bytes(wrap_bytes),
  .cmd_valid(cmd_valid)
);

/* File: tb/read_latency_wrap_config_tb.sv */
// Self-checking bench for the latency and wrap configuration register
`timescale 1ns/1ps
module read_latency_wrap_config_tb;
  logic core_clk, sys_rst, sck, cs_n, si, so, so_oe, soft_reset, quad_peripheral_mode;
  logic wrap_active, cmd_valid;
  logic [7:0] nv, cfg, exp_cfg, mexp;
  logic [5:0] dummy_cycles;
  logic [2:0] mode_cycles;
  logic [6:0] wrap_bytes;
  logic [63:0] rx;
  logic [31:0] seed = 32'h55fe;
  logic [7:0] ops [8] = '{8'h03, 8'h0b, 8'heb, 8'hed, 8'h4b, 8'hab, 8'h48, 8'h2b};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  read_latency_wrap_config i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .read_wrap_config_nonvolatile(nv), .soft_reset(soft_reset),
    .quad_peripheral_mode(quad_peripheral_mode), .read_wrap_config_volatile(cfg),
    .dummy_cycles(dummy_cycles), .mode_cycles(mode_cycles), .wrap_active(wrap_active),
    .wrap_bytes(wrap_bytes), .cmd_valid(cmd_valid));
  spi_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Expected dummy count per opcode
  function automatic logic [7:0] lat_exp(input logic [7:0] op, input logic [3:0] c);
    case (op)
      8'h03: return 8'h00;
      8'h4b: return 8'h20;
      8'hab: return 8'h18;
      8'h2b: return (c == 4'h0) ? 8'h01 : {4'h0, c};
      default: return (c == 4'h0) ? 8'h08 : {4'h0, c};
    endcase
  endfunction
  // Expected mode cycles; only quad reads carry them and only they may wrap
  function automatic logic [7:0] mode_exp(input logic [7:0] op, input logic qp);
    if (op == 8'heb || (qp && op == 8'h0b)) return 8'h02;
    if (op == 8'hed) return 8'h01;
    return 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd();
    i_host.xfer({48'h0, 8'h33, 8'h00}, 16, rx);
    chk(rx[7:0], exp_cfg);
    chk(cfg, exp_cfg);
    i_host.xfer({8'h0, 8'h65, 24'h800004, 8'h00}, 40, rx);
    chk(rx[7:0], exp_cfg);
    chk({7'h0, so_oe}, 8'h00);
  endtask
  // Write through write-registers, write-any or burst-length
  task automatic wr(input int m, input logic [7:0] v);
    if (m != 2) i_host.xfer({56'h0, 8'h50}, 8, rx);
    if (m == 0) i_host.xfer({24'h0, 8'h01, 24'h0, v}, 40, rx);
    else if (m == 1) i_host.xfer({24'h0, 8'h71, 24'h800004, v}, 40, rx);
    else i_host.xfer({48'h0, 8'h77, v}, 16, rx);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    sys_rst = 1'b1;
    soft_reset = 1'b0;
    quad_peripheral_mode = 1'b0;
    nv = rnd() | 8'h80;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    exp_cfg = nv & 8'h7f;
    rd();
    // Every latency code, each write path, then every opcode class
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      quad_peripheral_mode <= i[1];
      exp_cfg = (rnd() & 8'h70) | 8'(i);
      wr(i % 3, exp_cfg | 8'h80);
      rd();
      foreach (ops[k]) begin
        i_host.xfer({56'h0, ops[k]}, 8, rx);
        chk({2'h0, dummy_cycles}, lat_exp(ops[k], exp_cfg[3:0]));
        mexp = mode_exp(ops[k], quad_peripheral_mode);
        chk({5'h0, mode_cycles}, mexp);
        chk({7'h0, wrap_active}, {7'h0, mexp != 8'h00 && !exp_cfg[4]});
        chk({1'h0, wrap_bytes}, 8'h08 << exp_cfg[6:5]);
      end
    end
    // Write-any without enable, then to a foreign address
    i_host.xfer({24'h0, 8'h71, 24'h800004, 8'h5a}, 40, rx);
    rd();
    i_host.xfer({56'h0, 8'h50}, 8, rx);
    i_host.xfer({24'h0, 8'h71, 24'h800005, 8'h5a}, 40, rx);
    rd();
    @(posedge core_clk);
    nv <= ~nv;
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    exp_cfg = nv & 8'h7f;
    rd();
    summarize();
  end
endmodule

/* File: tb/spi_host_model.sv */
// Serial host that shifts frames in mode 0
`timescale 1ns/1ps
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Clock idles low between frames; 5 MHz stays far under the limits
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    // Start a little after the caller's edge so pins never move on it
    #7;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #100;
      sck = 1'b1;
      rx = {rx[62:0], so};
      #100;
      sck = 1'b0;
    end
    #100;
    cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule

/* File: verilog/cmd_link.sv */
`timescale 1ns/1ps
// Bundle from the serial front end to the register core
interface cmd_link;
  logic sck_rise;
  logic sck_fall;
  logic frame;
  logic mosi_bit;
  modport front (output sck_rise, output sck_fall, output frame, output mosi_bit);
  modport core (input sck_rise, input sck_fall, input frame, input mosi_bit);
endinterface

/* File: verilog/latency_cfg.svh */
// Constants for the read latency and wrap configuration register
// How it works
// [RL1] Wrap length code selects 8/16/32/64 bytes
// [RL2] Wrap enable one gives plain sequential read
// [RL3] Wrap enable zero wraps inside aligned group
// [RL4] Latency field selects 1 to 15 dummies
// [RL5] Register/security/parameter reads: code zero means eight
// [RL6] Host keeps latency code within frequency limits
// [RL7] Host clock at most 108 SDR, 54 DDR
// [RL8] Mode-bit cycles not counted as latency
// [RL9] Legacy quad read carries two mode cycles
// [RL10] Fixed latencies: read 0, id 32, wake 24
// [RL11] Opcode 33h returns this register
// [RL12] Reached via 50h, 01h, 65h, 71h, 77h
// [RL13] Latency field writable during normal operation
// [RL14] Wrap bits writable during normal operation
// [RL15] Bit 7 reserved, no function
// [RL16] Resets load fields from nonvolatile copy
// [RL17] Wrap applies only to quad reads
// [RL18] Protection reads: code zero means one
// [RL19] Changes apply from next command onward
// [RL20] Nonzero codes give that many dummies
`ifndef LATENCY_CFG_SVH
`define LATENCY_CFG_SVH
`define OP_READ_CFG3 8'h33
`define OP_WREN_VOL 8'h50
`define OP_WRITE_REGS 8'h01
`define OP_READ_ANY 8'h65
`define OP_WRITE_ANY 8'h71
`define OP_SET_BURST 8'h77
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_QUAD_IO_READ 8'heb
`define OP_QUAD_DDR_READ 8'hed
`define OP_READ_UID 8'h4b
`define OP_WAKE 8'hab
`define OP_READ_SECURITY 8'h48
`define OP_READ_PARAMS 8'h5a
`define OP_READ_PROTECT 8'h2b
`define ADDR_CFG3_VOL 24'h800004
`define WRAP_BIT 4
`define WRAP_LEN_LSB 5
`define LAT_MASK 8'h7f
`define LAT_DEFAULT 5'd8
`define LAT_PROT_DEFAULT 5'd1
`define LAT_UID 6'd32
`define LAT_WAKE 6'd24
`define MODE_QIO 3'd2
`define MODE_DDR 3'd1
`endif

/* File: verilog/latency_pkg.sv */
// Types shared by the configuration register modules
package latency_pkg;
  typedef enum logic [2:0] {
    cls_fixed0, cls_var, cls_prot, cls_uid, cls_wake
  } cmd_class_t;
  typedef enum logic [2:0] {
    st_op, st_addr, st_data_in, st_data_out, st_ignore
  } frame_state_t;
endpackage

/* File: verilog/read_latency_wrap_config.sv */
`timescale 1ns/1ps
// Volatile read latency and burst wrap configuration register
`include "latency_cfg.svh"
module read_latency_wrap_config
  import latency_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic [7:0] read_wrap_config_nonvolatile,
  input wire logic soft_reset,
  input wire logic quad_peripheral_mode,
  output logic [7:0] read_wrap_config_volatile,
  output logic [5:0] dummy_cycles,
  output logic [2:0] mode_cycles,
  output logic wrap_active,
  output logic [6:0] wrap_bytes,
  output logic cmd_valid
);
  typedef struct packed {
    frame_state_t fsm;
    logic [7:0] sh;
    logic [7:0] op;
    logic [23:0] addr;
    logic [5:0] cnt;
    logic [7:0] out_sh;
    logic wel;
    logic [7:0] cfg;
    logic [5:0] dummy;
    logic [2:0] mode;
    logic wrap;
    logic [6:0] wbytes;
    logic cval;
    logic so_q;
    logic load;
  } core_t;
  core_t st_ff, nxt_st;
  cmd_link link();
  // Opcode decode and the latency candidates published per command
  cmd_class_t cls;
  logic [5:0] var_lat;
  logic [5:0] prot_lat;
  logic [7:0] op_now;
  logic [5:0] pub_dummy;
  logic [2:0] pub_mode;
  logic pub_wrap;
  logic quad_read;

  // Pins cross into the core clock here; edges come out as pulses
  serial_sampler u_samp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .link(link)
  );

  // Opcode as it stands once its eighth bit arrives; the shifter alone lags one bit
  assign op_now = {st_ff.sh[6:0], link.mosi_bit};

  // Classify latency kind of the captured opcode
  always_comb begin
    if (op_now == `OP_FAST_READ || op_now == `OP_QUAD_IO_READ ||
        op_now == `OP_QUAD_DDR_READ || op_now == `OP_READ_ANY ||
        op_now == `OP_READ_SECURITY || op_now == `OP_READ_PARAMS) begin
      cls = cls_var;
    end else if (op_now == `OP_READ_PROTECT) begin
      cls = cls_prot;
    end else if (op_now == `OP_READ_UID) begin
      cls = cls_uid;
    end else if (op_now == `OP_WAKE) begin
      cls = cls_wake;
    end else begin
      cls = cls_fixed0; // RL10
    end
  end

  // Code zero maps to the default count, others literal
  assign var_lat = (st_ff.cfg[3:0] == 4'h0) ? {1'b0, `LAT_DEFAULT} :
                   {2'b00, st_ff.cfg[3:0]}; // RL4 RL5 RL20
  assign prot_lat = (st_ff.cfg[3:0] == 4'h0) ? {1'b0, `LAT_PROT_DEFAULT} :
                    {2'b00, st_ff.cfg[3:0]}; // RL18

  // Only the quad reads carry mode cycles and honour the wrap bit
  always_comb begin
    pub_mode = 3'd0;
    quad_read = 1'b0;
    if (op_now == `OP_QUAD_IO_READ) begin
      pub_mode = `MODE_QIO; // RL9 RL8
      quad_read = 1'b1;
    end else if (op_now == `OP_QUAD_DDR_READ) begin
      pub_mode = `MODE_DDR; // RL8
      quad_read = 1'b1;
    end else if (quad_peripheral_mode && op_now == `OP_FAST_READ) begin
      pub_mode = `MODE_QIO; // RL8
      quad_read = 1'b1;
    end
    pub_wrap = quad_read & ~st_ff.cfg[`WRAP_BIT]; // RL2 RL3 RL17
  end

  // Dummy count by latency class; mode cycles are never part of it
  always_comb begin
    case (cls)
      cls_var: pub_dummy = var_lat; // RL5 RL8
      cls_prot: pub_dummy = prot_lat; // RL18
      cls_uid: pub_dummy = `LAT_UID; // RL10
      cls_wake: pub_dummy = `LAT_WAKE; // RL10
      default: pub_dummy = 6'd0; // RL10
    endcase
  end

  // Command decode and register update
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cval = 1'b0;
    nxt_st.load = 1'b0;
    if (st_ff.load || soft_reset) begin
      nxt_st.cfg = read_wrap_config_nonvolatile & `LAT_MASK; // RL16 RL15
    end
    // Deselect ends any frame; a cut write never lands
    if (!link.frame) begin
      nxt_st.fsm = st_op;
      nxt_st.cnt = 6'd0;
      nxt_st.so_q = 1'b0;
    end else if (link.sck_fall && st_ff.fsm == st_data_out) begin
      nxt_st.so_q = st_ff.out_sh[7];
      nxt_st.out_sh = {st_ff.out_sh[6:0], st_ff.out_sh[7]};
    end else if (link.sck_rise) begin
      nxt_st.sh = {st_ff.sh[6:0], link.mosi_bit};
      nxt_st.cnt = st_ff.cnt + 6'd1;
      case (st_ff.fsm)
        st_op: begin
          if (st_ff.cnt == 6'd7) begin
            nxt_st.op = op_now;
            nxt_st.cnt = 6'd0;
            nxt_st.fsm = st_ignore;
            case (op_now)
              `OP_READ_CFG3: begin
                nxt_st.fsm = st_data_out; // RL11
                nxt_st.out_sh = st_ff.cfg;
              end
              `OP_WREN_VOL: nxt_st.wel = 1'b1; // RL12
              `OP_WRITE_REGS, `OP_SET_BURST: nxt_st.fsm = st_data_in;
              `OP_READ_ANY, `OP_WRITE_ANY: nxt_st.fsm = st_addr;
              default: nxt_st.fsm = st_ignore;
            endcase
          end
        end
        st_addr: begin
          nxt_st.addr = {st_ff.addr[22:0], link.mosi_bit};
          if (st_ff.cnt == 6'd23) begin
            nxt_st.cnt = 6'd0;
            if ({st_ff.addr[22:0], link.mosi_bit} != `ADDR_CFG3_VOL) begin
              nxt_st.fsm = st_ignore;
            end else if (st_ff.op == `OP_WRITE_ANY) begin
              nxt_st.fsm = st_data_in;
            end else begin
              nxt_st.fsm = st_data_out;
              nxt_st.out_sh = st_ff.cfg;
            end
          end
        end
        st_data_in: begin
          // Write-registers carries this register as its fourth byte
          if (st_ff.cnt[2:0] == 3'd7 && (st_ff.op != `OP_WRITE_REGS ||
              st_ff.cnt == 6'd31)) begin
            if (st_ff.wel || st_ff.op == `OP_SET_BURST) begin
              nxt_st.cfg = {st_ff.sh[6:0], link.mosi_bit} & `LAT_MASK; // RL13 RL14 RL15
            end
            nxt_st.wel = 1'b0;
            nxt_st.fsm = st_ignore;
          end
        end
        default: begin
          // Data-out and ignore phases only count bits until deselect
          nxt_st.fsm = st_ff.fsm;
        end
      endcase
    end
    // Publish per-command latency once the opcode is in; a later write waits for the next one
    if (link.frame && link.sck_rise && st_ff.fsm == st_op && st_ff.cnt == 6'd7) begin
      nxt_st.cval = 1'b1;
      nxt_st.dummy = pub_dummy; // RL19
      nxt_st.mode = pub_mode;
      nxt_st.wrap = pub_wrap; // RL17
      nxt_st.wbytes = 7'h08 << st_ff.cfg[6:`WRAP_LEN_LSB]; // RL1
    end
  end

  // Reset clears state and arms the nonvolatile load for the first free edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.load <= 1'b1; // RL16
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come from the state register; the enable follows the phase
  assign so = st_ff.so_q;
  assign so_oe = link.frame && st_ff.fsm == st_data_out;
  assign read_wrap_config_volatile = st_ff.cfg;
  assign dummy_cycles = st_ff.dummy;
  assign mode_cycles = st_ff.mode;
  assign wrap_active = st_ff.wrap;
  assign wrap_bytes = st_ff.wbytes;
  assign cmd_valid = st_ff.cval;
endmodule

/* File: verilog/serial_sampler.sv */
`timescale 1ns/1ps
// Synchronises serial pins to core clock and finds clock edges
module serial_sampler (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  cmd_link.front link
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sck_old;
  } samp_t;
  samp_t st_ff, nxt_st;

  // Two-flop sync, then edge detect on the second stage only
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {sck, cs_n, si};
    nxt_st.s2 = st_ff.s1;
    nxt_st.sck_old = st_ff.s2[2];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '{s1: 3'h2, s2: 3'h2, sck_old: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.sck_rise = st_ff.s2[2] & ~st_ff.sck_old & ~st_ff.s2[1];
  assign link.sck_fall = ~st_ff.s2[2] & st_ff.sck_old & ~st_ff.s2[1];
  assign link.frame = ~st_ff.s2[1];
  assign link.mosi_bit = st_ff.s2[0];
endmodule
